/* rtl/rtc_calendar_alarm_round_reset.sv */
// What this block does
// R01: Alarm hour holds BCD tens [5:4], units [3:0], upper bits zero.
// R02: Alarm date holds BCD day, tens [5:4], resets to one.
// R03: Alarm month keeps tens as bit 4, units low nibble, resets one.
// R04: Alarm year is an eight-bit BCD store cleared by reset.
// R05: Writing rounding enable bit 3 as one requests a seconds rounding.
// R06: Boundary codes 3, 4, 5 carry into minutes above 30, 40, 50.
// R07: Other boundary codes still clear seconds but never carry.
// R08: Seconds expose tens 0..5 in [6:4], units in [3:0].
// R09: Minutes expose tens 0..5 in [6:4], units low nibble, read/write.
// R10: Hours expose tens 0..2 in [5:4], units [3:0], [7:6] reserved.
// R11: Day of month exposes tens 0..3 in [5:4], units [3:0].
// R12: Weekday uses bits [2:0] with values 1 to 7.
// R13: Month tens is bit 4, units [3:0], bits [7:5] reserved.
// R14: Year holds two BCD digits 00 to 99, read/write.
// R15: Round reset zeroes seconds, adds a minute if past the boundary.
// R16: Software accesses every register as a single byte only.
// R17: Alarm fires when global enable bit 6 is set and all enabled fields equal current time fields.
// R18: Alarm raises interrupt; in power-off mode also the wake-up output.
// R19: BCD units roll nine to zero, counters wrap and carry onward.
// R20: Reserved bits read zero and ignore writes.
//
// The AXI4-Lite interface to the registers was decided locally.
module rtc_calendar_alarm_round_reset #(
	parameter int SECOND_CYCLES = rtc_cal_pkg::SECOND_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        power_off_mode,
	output logic             alarm_interrupt,
	output logic             power_wakeup_output
);

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic mapped(input logic [31:0] a);
		case (a)
			rtc_cal_pkg::ADDR_ALARM_ENABLE, rtc_cal_pkg::ADDR_ALARM_HOUR,
			rtc_cal_pkg::ADDR_ALARM_DATE, rtc_cal_pkg::ADDR_ALARM_MONTH,
			rtc_cal_pkg::ADDR_ALARM_YEAR, rtc_cal_pkg::ADDR_ROUNDING,
			rtc_cal_pkg::ADDR_TIME_SECONDS, rtc_cal_pkg::ADDR_TIME_MINUTES,
			rtc_cal_pkg::ADDR_TIME_HOURS, rtc_cal_pkg::ADDR_TIME_DATE,
			rtc_cal_pkg::ADDR_TIME_WEEKDAY, rtc_cal_pkg::ADDR_TIME_MONTH,
			rtc_cal_pkg::ADDR_TIME_YEAR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Wraps to low after top, units roll nine to zero
	function automatic logic [7:0] bcd_next(input logic [7:0] v,
		input logic [7:0] top, input logic [7:0] low);
		if (v == top)
			bcd_next = low;
		else if (v[3:0] == 4'h9)
			bcd_next = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_next = v + 8'h01;
	endfunction

	function automatic logic [7:0] month_last(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02: month_last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
			default: month_last = 8'h31;
		endcase
	endfunction

	function automatic logic [7:0] round_limit(input logic [2:0] code);
		case (code)
			rtc_cal_pkg::BOUND_30: round_limit = rtc_cal_pkg::LIMIT_30;
			rtc_cal_pkg::BOUND_40: round_limit = rtc_cal_pkg::LIMIT_40;
			rtc_cal_pkg::BOUND_50: round_limit = rtc_cal_pkg::LIMIT_50;
			default: round_limit = rtc_cal_pkg::LIMIT_NONE;
		endcase
	endfunction

	logic [7:0]  alarm_enable_control;
	logic [7:0]  alarm_hour;
	logic [7:0]  alarm_day_of_month;
	logic [7:0]  alarm_month;
	logic [7:0]  alarm_year;
	logic [7:0]  seconds_rounding_control;
	logic [7:0]  time_seconds;
	logic [7:0]  time_minutes;
	logic [7:0]  time_hours;
	logic [7:0]  time_day_of_month;
	logic [7:0]  time_weekday;
	logic [7:0]  time_month;
	logic [7:0]  time_year;
	logic [31:0] div_cnt;
	logic        sec_tick;
	logic        pwr_meta;
	logic        pwr_sync;
	logic        match_q;
	logic        wr_go;
	logic [7:0]  wr_byte;
	logic        round_req;
	logic        round_carry;
	logic        inc_min;
	logic        inc_hour;
	logic        inc_day;
	logic        inc_month;
	logic        inc_year;
	logic        alarm_match;
	logic [7:0]  rd_byte;

	// ************************************************
	// Register bus
	// ************************************************
	// Both address and data taken together, one cycle after both are valid
	assign wr_go   = awready & awvalid & wready & wvalid & wstrb[0]; // [R16]
	assign wr_byte = wdata[7:0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= rtc_cal_pkg::RESP_OKAY;
		end
		else if (awready)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b1;
			bresp   <= mapped(awaddr) ? rtc_cal_pkg::RESP_OKAY
				: rtc_cal_pkg::RESP_SLVERR;
		end
		else if (bvalid)
			bvalid <= !bready;
		else if (awvalid && wvalid)
		begin
			awready <= 1'b1;
			wready  <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= rtc_cal_pkg::RESP_OKAY;
		end
		else if (arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h00_0000, rd_byte};
			rresp   <= mapped(araddr) ? rtc_cal_pkg::RESP_OKAY
				: rtc_cal_pkg::RESP_SLVERR;
		end
		else if (rvalid)
			rvalid <= !rready;
		else if (arvalid)
			arready <= 1'b1;
	end

	always_comb
	begin
		case (araddr)
			rtc_cal_pkg::ADDR_ALARM_ENABLE: rd_byte = alarm_enable_control;
			rtc_cal_pkg::ADDR_ALARM_HOUR:   rd_byte = alarm_hour;
			rtc_cal_pkg::ADDR_ALARM_DATE:   rd_byte = alarm_day_of_month;
			rtc_cal_pkg::ADDR_ALARM_MONTH:  rd_byte = alarm_month;
			rtc_cal_pkg::ADDR_ALARM_YEAR:   rd_byte = alarm_year;
			rtc_cal_pkg::ADDR_ROUNDING:     rd_byte = seconds_rounding_control;
			rtc_cal_pkg::ADDR_TIME_SECONDS: rd_byte = time_seconds;
			rtc_cal_pkg::ADDR_TIME_MINUTES: rd_byte = time_minutes;
			rtc_cal_pkg::ADDR_TIME_HOURS:   rd_byte = time_hours;
			rtc_cal_pkg::ADDR_TIME_DATE:    rd_byte = time_day_of_month;
			rtc_cal_pkg::ADDR_TIME_WEEKDAY: rd_byte = time_weekday;
			rtc_cal_pkg::ADDR_TIME_MONTH:   rd_byte = time_month;
			rtc_cal_pkg::ADDR_TIME_YEAR:    rd_byte = time_year;
			default:                        rd_byte = 8'h00;
		endcase
	end

	// ************************************************
	// Alarm and rounding registers
	// ************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alarm_enable_control <= rtc_cal_pkg::RST_ZERO;
			alarm_hour           <= rtc_cal_pkg::RST_ZERO; // [R01]
			alarm_day_of_month   <= rtc_cal_pkg::RST_ONE;  // [R02]
			alarm_month          <= rtc_cal_pkg::RST_ONE;  // [R03]
			alarm_year           <= rtc_cal_pkg::RST_ZERO; // [R04]
			seconds_rounding_control <= rtc_cal_pkg::RST_ZERO;
		end
		else if (wr_go)
		begin
			case (awaddr)
				rtc_cal_pkg::ADDR_ALARM_ENABLE: alarm_enable_control <=
					wr_byte & rtc_cal_pkg::MASK_ALARM_ENABLE;
				rtc_cal_pkg::ADDR_ALARM_HOUR: alarm_hour <=
					wr_byte & rtc_cal_pkg::MASK_HOUR; // [R01] [R20]
				rtc_cal_pkg::ADDR_ALARM_DATE: alarm_day_of_month <=
					wr_byte & rtc_cal_pkg::MASK_DATE; // [R02]
				rtc_cal_pkg::ADDR_ALARM_MONTH: alarm_month <=
					wr_byte & rtc_cal_pkg::MASK_MONTH; // [R03]
				rtc_cal_pkg::ADDR_ALARM_YEAR: alarm_year <=
					wr_byte & rtc_cal_pkg::MASK_YEAR; // [R04]
				rtc_cal_pkg::ADDR_ROUNDING: seconds_rounding_control <=
					wr_byte & rtc_cal_pkg::MASK_ROUNDING; // [R05]
				default: ;
			endcase
		end
	end

	// ************************************************
	// Second divider and time counters
	// ************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt  <= 32'h0000_0000;
			sec_tick <= 1'b0;
		end
		else
		begin
			sec_tick <= (div_cnt == 32'(SECOND_CYCLES - 1));
			div_cnt  <= (div_cnt == 32'(SECOND_CYCLES - 1)) ? 32'h0000_0000
				: div_cnt + 32'h0000_0001;
		end
	end

	// Rounding acts on the write itself; the stored enable only reads back
	assign round_req = wr_go && awaddr == rtc_cal_pkg::ADDR_ROUNDING
		&& wr_byte[rtc_cal_pkg::ROUND_ENABLE_BIT]; // [R05]
	assign round_carry = round_req
		&& time_seconds > round_limit(wr_byte[2:0]); // [R06] [R07]
	assign inc_min   = (sec_tick && time_seconds == rtc_cal_pkg::MAX_SEC_MIN)
		|| round_carry; // [R15]
	assign inc_hour  = inc_min && time_minutes == rtc_cal_pkg::MAX_SEC_MIN;
	assign inc_day   = inc_hour && time_hours == rtc_cal_pkg::MAX_HOUR;
	assign inc_month = inc_day
		&& time_day_of_month == month_last(time_month, time_year);
	assign inc_year  = inc_month && time_month == rtc_cal_pkg::MAX_MONTH;

	// Bus write to a field beats the count in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			time_seconds      <= rtc_cal_pkg::RST_ZERO;
			time_minutes      <= rtc_cal_pkg::RST_ZERO;
			time_hours        <= rtc_cal_pkg::RST_ZERO;
			time_day_of_month <= rtc_cal_pkg::RST_ONE;
			time_weekday      <= rtc_cal_pkg::RST_ONE;
			time_month        <= rtc_cal_pkg::RST_ONE;
			time_year         <= rtc_cal_pkg::RST_ZERO;
		end
		else
		begin
			if (round_req)
				time_seconds <= rtc_cal_pkg::RST_ZERO; // [R15] [R07]
			else if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_SECONDS)
				time_seconds <= wr_byte & rtc_cal_pkg::MASK_MIN_SEC; // [R08]
			else if (sec_tick)
				time_seconds <= bcd_next(time_seconds,
					rtc_cal_pkg::MAX_SEC_MIN, rtc_cal_pkg::RST_ZERO); // [R19]
			if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_MINUTES)
				time_minutes <= wr_byte & rtc_cal_pkg::MASK_MIN_SEC; // [R09]
			else if (inc_min)
				time_minutes <= bcd_next(time_minutes,
					rtc_cal_pkg::MAX_SEC_MIN, rtc_cal_pkg::RST_ZERO); // [R19]
			if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_HOURS)
				time_hours <= wr_byte & rtc_cal_pkg::MASK_HOUR; // [R10]
			else if (inc_hour)
				time_hours <= bcd_next(time_hours,
					rtc_cal_pkg::MAX_HOUR, rtc_cal_pkg::RST_ZERO);
			if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_DATE)
				time_day_of_month <= wr_byte & rtc_cal_pkg::MASK_DATE; // [R11]
			else if (inc_day)
				time_day_of_month <= bcd_next(time_day_of_month,
					month_last(time_month, time_year), rtc_cal_pkg::RST_ONE);
			if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_WEEKDAY)
				time_weekday <= wr_byte & rtc_cal_pkg::MASK_WEEKDAY; // [R12]
			else if (inc_day)
				time_weekday <= bcd_next(time_weekday,
					rtc_cal_pkg::MAX_WEEKDAY, rtc_cal_pkg::RST_ONE); // [R12]
			if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_MONTH)
				time_month <= wr_byte & rtc_cal_pkg::MASK_MONTH; // [R13] [R20]
			else if (inc_month)
				time_month <= bcd_next(time_month,
					rtc_cal_pkg::MAX_MONTH, rtc_cal_pkg::RST_ONE);
			if (wr_go && awaddr == rtc_cal_pkg::ADDR_TIME_YEAR)
				time_year <= wr_byte; // [R14]
			else if (inc_year)
				time_year <= bcd_next(time_year,
					rtc_cal_pkg::MAX_YEAR, rtc_cal_pkg::RST_ZERO); // [R14]
		end
	end

	// ************************************************
	// Alarm compare and outputs
	// ************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwr_meta <= 1'b0;
			pwr_sync <= 1'b0;
		end
		else
		begin
			pwr_meta <= power_off_mode;
			pwr_sync <= pwr_meta;
		end
	end

	assign alarm_match = alarm_enable_control[rtc_cal_pkg::EN_GLOBAL_BIT]
		&& (!alarm_enable_control[rtc_cal_pkg::EN_YEAR_BIT]
			|| alarm_year == time_year)
		&& (!alarm_enable_control[rtc_cal_pkg::EN_MONTH_BIT]
			|| alarm_month == time_month)
		&& (!alarm_enable_control[rtc_cal_pkg::EN_DATE_BIT]
			|| alarm_day_of_month == time_day_of_month)
		&& (!alarm_enable_control[rtc_cal_pkg::EN_HOUR_BIT]
			|| alarm_hour == time_hours); // [R17]

	// One pulse per entry into a match, not a level for the whole hour
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			match_q             <= 1'b0;
			alarm_interrupt     <= 1'b0;
			power_wakeup_output <= 1'b0;
		end
		else
		begin
			match_q             <= alarm_match;
			alarm_interrupt     <= alarm_match && !match_q; // [R18]
			power_wakeup_output <= alarm_match && !match_q && pwr_sync; // [R18]
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_round(logic [2:0] code);
		round_req && !sec_tick && wr_byte[2:0] == code;
	endsequence

	sequence s_fire;
		alarm_match && !match_q;
	endsequence

	AST_ALARM_HOUR_RESV: assert property (alarm_hour[7:6] == 2'h0) // [R01]
		else $error("alarm hour reserved bits set");
	AST_ALARM_DATE_RST: assert property ($rose(aresetn)
		|-> alarm_day_of_month == 8'h01) // [R02]
		else $error("alarm date reset value wrong");
	AST_ALARM_MONTH_RESV: assert property (alarm_month[7:5] == 3'h0) // [R03]
		else $error("alarm month reserved bits set");
	AST_ROUND_CARRY: assert property (s_round(3'h4)
		and (time_seconds > 8'h40 && time_minutes == 8'h10)
		|=> time_minutes == 8'h11 && time_seconds == 8'h00) // [R06]
		else $error("rounding past 40 did not carry");
	AST_ROUND_NO_CARRY: assert property (s_round(3'h7)
		|=> $stable(time_minutes) && time_seconds == 8'h00) // [R07]
		else $error("undefined boundary code changed minutes");
	AST_SEC_FORMAT: assert property (time_seconds[7] == 1'b0
		&& time_seconds[6:4] <= 3'h5) // [R08]
		else $error("seconds out of BCD range");
	AST_WEEKDAY_RANGE: assert property (time_weekday >= 8'h01
		&& time_weekday <= 8'h07) // [R12]
		else $error("weekday out of range");
	AST_UNITS_ROLL: assert property (sec_tick && !wr_go
		&& time_seconds == 8'h09 |=> time_seconds == 8'h10) // [R19]
		else $error("seconds units did not roll");
	AST_ALARM_FIRE: assert property (s_fire |=> alarm_interrupt
		##1 !alarm_interrupt) // [R17]
		else $error("alarm match did not pulse interrupt");
	AST_WAKEUP: assert property (power_wakeup_output
		|-> alarm_interrupt && $past(pwr_sync)) // [R18]
		else $error("wake-up without alarm in power-off");

endmodule

/* pkg/rtc_cal_pkg.sv */
package rtc_cal_pkg;

	// ************************************************
	// Register byte addresses
	// ************************************************
	localparam logic [31:0] ADDR_ALARM_ENABLE   = 32'h5700_0050;
	localparam logic [31:0] ADDR_ALARM_HOUR     = 32'h5700_005C;
	localparam logic [31:0] ADDR_ALARM_DATE     = 32'h5700_0060;
	localparam logic [31:0] ADDR_ALARM_MONTH    = 32'h5700_0064;
	localparam logic [31:0] ADDR_ALARM_YEAR     = 32'h5700_0068;
	localparam logic [31:0] ADDR_ROUNDING       = 32'h5700_006C;
	localparam logic [31:0] ADDR_TIME_SECONDS   = 32'h5700_0070;
	localparam logic [31:0] ADDR_TIME_MINUTES   = 32'h5700_0074;
	localparam logic [31:0] ADDR_TIME_HOURS     = 32'h5700_0078;
	localparam logic [31:0] ADDR_TIME_DATE      = 32'h5700_007C;
	localparam logic [31:0] ADDR_TIME_WEEKDAY   = 32'h5700_0080;
	localparam logic [31:0] ADDR_TIME_MONTH     = 32'h5700_0084;
	localparam logic [31:0] ADDR_TIME_YEAR      = 32'h5700_0088;

	// ************************************************
	// Implemented bits of each register
	// ************************************************
	localparam logic [7:0] MASK_ALARM_ENABLE = 8'h7C;
	localparam logic [7:0] MASK_HOUR         = 8'h3F;
	localparam logic [7:0] MASK_DATE         = 8'h3F;
	localparam logic [7:0] MASK_MONTH        = 8'h1F;
	localparam logic [7:0] MASK_YEAR         = 8'hFF;
	localparam logic [7:0] MASK_ROUNDING     = 8'h0F;
	localparam logic [7:0] MASK_MIN_SEC      = 8'h7F;
	localparam logic [7:0] MASK_WEEKDAY      = 8'h07;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int ROUND_ENABLE_BIT = 3;
	localparam int EN_GLOBAL_BIT    = 6;
	localparam int EN_YEAR_BIT      = 5;
	localparam int EN_MONTH_BIT     = 4;
	localparam int EN_DATE_BIT      = 3;
	localparam int EN_HOUR_BIT      = 2;

	// ************************************************
	// Boundary codes and limits
	// ************************************************
	localparam logic [2:0] BOUND_30 = 3'h3;
	localparam logic [2:0] BOUND_40 = 3'h4;
	localparam logic [2:0] BOUND_50 = 3'h5;
	localparam logic [7:0] LIMIT_30 = 8'h30;
	localparam logic [7:0] LIMIT_40 = 8'h40;
	localparam logic [7:0] LIMIT_50 = 8'h50;
	localparam logic [7:0] LIMIT_NONE = 8'hFF;
	localparam logic [7:0] MAX_SEC_MIN = 8'h59;
	localparam logic [7:0] MAX_HOUR    = 8'h23;
	localparam logic [7:0] MAX_MONTH   = 8'h12;
	localparam logic [7:0] MAX_YEAR    = 8'h99;
	localparam logic [7:0] MAX_WEEKDAY = 8'h07;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ONE  = 8'h01;

	// ************************************************
	// Bus answers and timing
	// ************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam longint CLK_PERIOD_NS = 50;
	localparam longint SECOND_NS     = 1000000000;
	localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage

/* dv/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************
	// Signals
	// ************************************************
	localparam int SEC_CYC = 200;
	logic        aclk           = 1'b0;
	logic        aresetn        = 1'b0;
	logic [31:0] awaddr         = 32'h0;
	logic        awvalid        = 1'b0;
	logic        awready;
	logic [31:0] wdata          = 32'h0;
	logic [3:0]  wstrb          = 4'h0;
	logic        wvalid         = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready         = 1'b0;
	logic [31:0] araddr         = 32'h0;
	logic        arvalid        = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready         = 1'b0;
	logic        power_off_mode = 1'b0;
	logic        alarm_interrupt;
	logic        power_wakeup_output;
	int          err_total      = 0;
	int          checks_done    = 0;
	int          irq_cnt        = 0;
	int          wake_cnt       = 0;

	always #25 aclk = ~aclk;

	always @(posedge aclk)
	begin
		if (alarm_interrupt === 1'b1)
			irq_cnt <= irq_cnt + 1;
		if (power_wakeup_output === 1'b1)
			wake_cnt <= wake_cnt + 1;
	end

	rtc_calendar_alarm_round_reset #(
		.SECOND_CYCLES(SEC_CYC)
	) rtc_calendar_alarm_round_reset_inst (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.power_off_mode(power_off_mode),
		.alarm_interrupt(alarm_interrupt),
		.power_wakeup_output(power_wakeup_output)
	);

	// ************************************************
	// Bus and compare tasks
	// ************************************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awready === 1'b1)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do
			@(posedge aclk);
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// Idle edge so the next call never re-raises bready in this step
		@(posedge aclk);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic wrok(input logic [31:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, 4'h1, r);
		chk("write resp", {30'h0, rtc_cal_pkg::RESP_OKAY}, {30'h0, r});
	endtask

	task automatic rdchk(input string what, input logic [31:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(what, exp, d);
		chk("read resp", {30'h0, rtc_cal_pkg::RESP_OKAY}, {30'h0, r});
	endtask

	// Align to a fresh second so no tick lands inside a test
	task automatic sync_tick();
		logic [31:0] s0;
		logic [31:0] s;
		logic [1:0]  r;
		rd(rtc_cal_pkg::ADDR_TIME_SECONDS, s0, r);
		s = s0;
		while (s === s0)
			rd(rtc_cal_pkg::ADDR_TIME_SECONDS, s, r);
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic test_reset();
		rdchk("alarm hour", rtc_cal_pkg::ADDR_ALARM_HOUR, 32'h0);
		rdchk("alarm date", rtc_cal_pkg::ADDR_ALARM_DATE, 32'h1);
		rdchk("alarm month", rtc_cal_pkg::ADDR_ALARM_MONTH, 32'h1);
		rdchk("alarm year", rtc_cal_pkg::ADDR_ALARM_YEAR, 32'h0);
		rdchk("rounding", rtc_cal_pkg::ADDR_ROUNDING, 32'h0);
		rdchk("minutes", rtc_cal_pkg::ADDR_TIME_MINUTES, 32'h0);
		rdchk("weekday", rtc_cal_pkg::ADDR_TIME_WEEKDAY, 32'h1);
		$display("test reset values done");
	endtask

	task automatic test_alarm_regs();
		logic [31:0] d;
		logic [1:0]  r;
		wrok(rtc_cal_pkg::ADDR_ALARM_HOUR, 8'hFF);
		rdchk("alarm hour", rtc_cal_pkg::ADDR_ALARM_HOUR, 32'h3F);
		wrok(rtc_cal_pkg::ADDR_ALARM_DATE, 8'hFF);
		rdchk("alarm date", rtc_cal_pkg::ADDR_ALARM_DATE, 32'h3F);
		wrok(rtc_cal_pkg::ADDR_ALARM_MONTH, 8'hFF);
		rdchk("alarm month", rtc_cal_pkg::ADDR_ALARM_MONTH, 32'h1F);
		wrok(rtc_cal_pkg::ADDR_ALARM_YEAR, 8'h47);
		wr(rtc_cal_pkg::ADDR_ALARM_YEAR, 8'h12, 4'h0, r);
		rdchk("alarm year", rtc_cal_pkg::ADDR_ALARM_YEAR, 32'h47);
		wr(32'h5700_0090, 8'h55, 4'h1, r);
		chk("unmapped write", 32'h2, {30'h0, r});
		rd(32'h5700_0090, d, r);
		chk("unmapped read", 32'h2, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		$display("test alarm registers done");
	endtask

	task automatic test_time_fields();
		sync_tick();
		wrok(rtc_cal_pkg::ADDR_TIME_SECONDS, 8'hD8);
		wrok(rtc_cal_pkg::ADDR_TIME_MINUTES, 8'hD9);
		wrok(rtc_cal_pkg::ADDR_TIME_HOURS, 8'hE3);
		wrok(rtc_cal_pkg::ADDR_TIME_DATE, 8'hF1);
		wrok(rtc_cal_pkg::ADDR_TIME_WEEKDAY, 8'hFF);
		wrok(rtc_cal_pkg::ADDR_TIME_MONTH, 8'hF2);
		wrok(rtc_cal_pkg::ADDR_TIME_YEAR, 8'h99);
		rdchk("seconds", rtc_cal_pkg::ADDR_TIME_SECONDS, 32'h58);
		rdchk("minutes", rtc_cal_pkg::ADDR_TIME_MINUTES, 32'h59);
		rdchk("hours", rtc_cal_pkg::ADDR_TIME_HOURS, 32'h23);
		rdchk("date", rtc_cal_pkg::ADDR_TIME_DATE, 32'h31);
		rdchk("weekday", rtc_cal_pkg::ADDR_TIME_WEEKDAY, 32'h7);
		rdchk("month", rtc_cal_pkg::ADDR_TIME_MONTH, 32'h12);
		rdchk("year", rtc_cal_pkg::ADDR_TIME_YEAR, 32'h99);
		sync_tick();
		sync_tick();
		rdchk("minutes", rtc_cal_pkg::ADDR_TIME_MINUTES, 32'h0);
		rdchk("hours", rtc_cal_pkg::ADDR_TIME_HOURS, 32'h0);
		rdchk("date", rtc_cal_pkg::ADDR_TIME_DATE, 32'h1);
		rdchk("weekday", rtc_cal_pkg::ADDR_TIME_WEEKDAY, 32'h1);
		rdchk("month", rtc_cal_pkg::ADDR_TIME_MONTH, 32'h1);
		rdchk("year", rtc_cal_pkg::ADDR_TIME_YEAR, 32'h0);
		$display("test time rollover done");
	endtask

	// Entry: control, seconds before, seconds after, minutes after
	task automatic test_rounding();
		logic [31:0] tab [13] = '{32'h0B31_0011, 32'h0B30_0010,
			32'h0C40_0010, 32'h0C41_0011, 32'h0D50_0010, 32'h0D59_0011,
			32'h0859_0010, 32'h0959_0010, 32'h0A59_0010, 32'h0E59_0010,
			32'h0F59_0010, 32'h0547_4710, 32'hFB47_0011};
		for (int i = 0; i < 13; i++)
		begin
			sync_tick();
			wrok(rtc_cal_pkg::ADDR_TIME_MINUTES, 8'h10);
			wrok(rtc_cal_pkg::ADDR_TIME_SECONDS, tab[i][23:16]);
			wrok(rtc_cal_pkg::ADDR_ROUNDING, tab[i][31:24]);
			rdchk("round seconds", rtc_cal_pkg::ADDR_TIME_SECONDS,
				{24'h0, tab[i][15:8]});
			rdchk("round minutes", rtc_cal_pkg::ADDR_TIME_MINUTES,
				{24'h0, tab[i][7:0]});
			rdchk("round control", rtc_cal_pkg::ADDR_ROUNDING,
				{28'h0, tab[i][27:24]});
		end
		$display("test rounding done");
	endtask

	task automatic test_alarm();
		sync_tick();
		wrok(rtc_cal_pkg::ADDR_TIME_HOURS, 8'h05);
		wrok(rtc_cal_pkg::ADDR_ALARM_HOUR, 8'h05);
		wrok(rtc_cal_pkg::ADDR_ALARM_ENABLE, 8'h44);
		repeat (3) @(posedge aclk);
		chk("alarm pulses", 32'd1, irq_cnt);
		chk("wakeup pulses", 32'd0, wake_cnt);
		wrok(rtc_cal_pkg::ADDR_ALARM_ENABLE, 8'h00);
		power_off_mode <= 1'b1;
		repeat (4) @(posedge aclk);
		wrok(rtc_cal_pkg::ADDR_ALARM_ENABLE, 8'h44);
		repeat (3) @(posedge aclk);
		chk("alarm pulses", 32'd2, irq_cnt);
		chk("wakeup pulses", 32'd1, wake_cnt);
		wrok(rtc_cal_pkg::ADDR_ALARM_ENABLE, 8'h00);
		wrok(rtc_cal_pkg::ADDR_ALARM_HOUR, 8'h06);
		wrok(rtc_cal_pkg::ADDR_ALARM_ENABLE, 8'h44);
		repeat (3) @(posedge aclk);
		chk("alarm pulses", 32'd2, irq_cnt);
		power_off_mode <= 1'b0;
		$display("test alarm match done");
	endtask

	// ************************************************
	// Verdict and sequence
	// ************************************************
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_reset();
		test_alarm_regs();
		test_time_fields();
		test_rounding();
		test_alarm();
		results();
	end

	// Whole run needs about 3500 cycles
	initial
	begin
		repeat (20000) @(posedge aclk);
		$display("watchdog expired");
		err_total++;
		results();
	end
endmodule
